// >>> rtl/ddr_cmd_front.sv
`timescale 1ns/1ns
`default_nettype none

module ddr_cmd_front
    import ddr_cmd_pkg::*;
(
    // clock and reset
    input  wire logic               i_mclk,
    input  wire logic               i_reset_n,
    // command and address pins
    input  wire logic               i_cke,
    input  wire cmd_s               i_cmd,
    // write data with byte masks
    input  wire wr_in_s             i_wr,
    // storage array answer
    input  wire pair_s              i_arr_rdata,
    // storage array request
    output arr_req_s                o_arr,
    // read data, one word per clock phase
    output rd_out_s                 o_rd,
    // status
    output logic [N_BANKS-1:0]      o_bank_open,
    output logic                    o_dll_enable,
    output logic                    o_clock_suspended,
    output logic                    o_power_down,
    output logic                    o_self_refresh
);
    state_s             st_reg;
    state_s             st_next;
    logic [2:0]         cmd_code;
    logic               cmd_valid;
    logic               live;
    logic [3:0]         bl_len;
    logic               last_pair;
    logic [COL_W-1:0]   col_rise;
    logic [COL_W-1:0]   col_fall;
    logic               src_v;
    pair_s              src;
    logic [2:0]         beat_fall;

    assign cmd_code  = {i_cmd.ras_n, i_cmd.cas_n, i_cmd.we_n};
    assign cmd_valid = !i_cmd.cs_n;
    // clock acts at this edge only if enable was high one edge earlier
    assign live      = st_reg.cke_prev;
    assign beat_fall = st_reg.beat + 3'h1;

    always_comb begin
        case (st_reg.bl_code)
            BL_CODE_4: bl_len = BL_LEN_4;
            BL_CODE_8: bl_len = BL_LEN_8;
            default:   bl_len = BL_LEN_2;
        endcase
        last_pair = ({1'b0, st_reg.beat} + 4'(BEAT_STEP)) >= bl_len;
    end

    burst_addr_gen u_col_rise (
        .i_start_col  (st_reg.bcol),
        .i_beat       (st_reg.beat),
        .i_burst_len  (bl_len),
        .i_interleave (st_reg.interleave),
        .o_col        (col_rise)
    );

    burst_addr_gen u_col_fall (
        .i_start_col  (st_reg.bcol),
        .i_beat       (beat_fall),
        .i_burst_len  (bl_len),
        .i_interleave (st_reg.interleave),
        .o_col        (col_fall)
    );

    // latency 3 adds one stage; 2 and 2.5 take array data directly
    always_comb begin
        if (st_reg.cl_code == CL_CODE_3) begin
            src_v = st_reg.rd1_v;
            src   = st_reg.rd1;
        end else begin
            src_v = st_reg.arr.rd;
            src   = i_arr_rdata;
        end
    end

    always_comb begin
        st_next          = st_reg;
        st_next.cke_prev = i_cke;
        st_next.arr.rd   = 1'b0;
        st_next.arr.wr   = 1'b0;
        if (live) begin
            // burst engine: two words per clock, one per phase
            if (st_reg.burst != BURST_IDLE) begin
                st_next.arr.rd    = (st_reg.burst == BURST_READ);
                st_next.arr.wr    = (st_reg.burst == BURST_WRITE);
                st_next.arr.addr_rise = {st_reg.bbank, st_reg.brow,
                                         col_rise};
                st_next.arr.addr_fall = {st_reg.bbank, st_reg.brow,
                                         col_fall};
                st_next.arr.wdata = i_wr.data;
                // masked bytes carry no enable, same cycle as data
                st_next.arr.wen_rise = ~i_wr.write_byte_mask_rise;
                st_next.arr.wen_fall = ~i_wr.write_byte_mask_fall;
                st_next.beat = st_reg.beat + BEAT_STEP;
                if (last_pair) begin
                    st_next.burst = BURST_IDLE;
                    st_next.beat  = 3'h0;
                    if (st_reg.bap) begin
                        st_next.bank_open[st_reg.bbank] = 1'b0;
                    end
                end
            end
            // read return pipeline
            st_next.rd1_v = st_reg.arr.rd;
            st_next.rd1   = i_arr_rdata;
            if (st_reg.cl_code == CL_CODE_25) begin
                // half clock: fall word of one pair leads the next rise
                st_next.rd.valid     = src_v | st_reg.prev_v;
                st_next.rd.data.rise = st_reg.prev_fall;
                st_next.rd.data.fall = src.rise;
                st_next.prev_fall    = src.fall;
                st_next.prev_v       = src_v;
            end else begin
                st_next.rd.valid = src_v;
                st_next.rd.data  = src;
                st_next.prev_v   = 1'b0;
            end
            // command decoder
            if (cmd_valid) begin
                case (cmd_code)
                    CMD_ROW_OPEN: begin
                        st_next.bank_open[i_cmd.bank_select] = 1'b1;
                        st_next.open_row[i_cmd.bank_select] =
                            i_cmd.row_column_address_bus;
                    end
                    CMD_PRECHARGE: begin
                        if (i_cmd.row_column_address_bus[AP_BIT]) begin
                            st_next.bank_open = '0;
                        end else begin
                            st_next.bank_open[i_cmd.bank_select] = 1'b0;
                        end
                    end
                    CMD_READ, CMD_WRITE: begin
                        st_next.burst = (cmd_code == CMD_READ) ?
                                        BURST_READ : BURST_WRITE;
                        st_next.bbank = i_cmd.bank_select;
                        st_next.brow  = st_reg.open_row[i_cmd.bank_select];
                        st_next.bcol  =
                            i_cmd.row_column_address_bus[COL_W-1:0];
                        st_next.bap   =
                            i_cmd.row_column_address_bus[AP_BIT];
                        st_next.beat  = 3'h0;
                    end
                    CMD_MODE: begin
                        if (i_cmd.bank_select == BANK_MODE) begin
                            st_next.bl_code = i_cmd.row_column_address_bus
                                              [MR_BL_LSB +: 3];
                            st_next.interleave = i_cmd.row_column_address_bus
                                                 [MR_BT_BIT];
                            st_next.cl_code = i_cmd.row_column_address_bus
                                              [MR_CL_LSB +: 3];
                        end else if (i_cmd.bank_select == BANK_EXT_MODE) begin
                            // extended_mode_load: bit set turns loop off
                            st_next.dll_en = !i_cmd.row_column_address_bus
                                             [EMR_DLL_BIT];
                        end
                    end
                    default: begin
                    end
                endcase
            end
            // enable dropping: low-power only with every bank idle
            if (!i_cke) begin
                if (st_reg.bank_open == '0 &&
                    st_next.bank_open == '0 &&
                    st_next.burst == BURST_IDLE) begin
                    st_next.pm = (cmd_valid && cmd_code == CMD_REFRESH) ?
                                 PM_SELF_REFRESH : PM_POWER_DOWN;
                end else begin
                    st_next.pm = PM_SUSPEND;
                end
            end else begin
                st_next.pm = PM_ACTIVE;
            end
        end else if (i_cke) begin
            // state frozen this edge; clock resumes on the next one
            st_next.pm = PM_ACTIVE;
        end
    end

    // single edge: nothing is sampled on the falling phase
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_arr             = st_reg.arr;
    assign o_rd              = st_reg.rd;
    assign o_bank_open       = st_reg.bank_open;
    assign o_dll_enable      = st_reg.dll_en;
    assign o_clock_suspended = (st_reg.pm == PM_SUSPEND);
    assign o_power_down      = (st_reg.pm == PM_POWER_DOWN);
    assign o_self_refresh    = (st_reg.pm == PM_SELF_REFRESH);

    default clocking cb @(posedge i_mclk);
    endclocking

    default disable iff (!i_reset_n);

    AST_CS_MASK: assert property (
        live && i_cmd.cs_n && st_reg.burst == BURST_IDLE
        |=> $stable(st_reg.bank_open) && st_reg.burst == BURST_IDLE)
        else $error("command taken with chip select high");

    AST_ROW_OPEN: assert property (
        live && cmd_valid && cmd_code == CMD_ROW_OPEN
        |=> st_reg.bank_open[$past(i_cmd.bank_select)] &&
            st_reg.open_row[$past(i_cmd.bank_select)] ==
            $past(i_cmd.row_column_address_bus))
        else $error("row open did not capture row");

    AST_PRECHARGE: assert property (
        live && cmd_valid && cmd_code == CMD_PRECHARGE
        |=> !st_reg.bank_open[$past(i_cmd.bank_select)])
        else $error("precharge left bank open");

    AST_READ_LAT2: assert property (
        live && cmd_valid && cmd_code == CMD_READ &&
        st_reg.cl_code != CL_CODE_3 && st_reg.cl_code != CL_CODE_25 &&
        i_cke ##1 i_cke
        |=> ##1 st_reg.rd.valid)
        else $error("latency 2 read data late");

    AST_AUTO_PRE: assert property (
        live && st_reg.burst != BURST_IDLE && last_pair && st_reg.bap &&
        !cmd_valid
        |=> !st_reg.bank_open[$past(st_reg.bbank)] &&
            st_reg.burst == BURST_IDLE)
        else $error("auto precharge did not close row");

    AST_SUSPEND: assert property (
        !live |=> $stable(st_reg.rd) && $stable(st_reg.beat) &&
                  $stable(st_reg.burst) && !st_reg.arr.rd)
        else $error("state moved while clock suspended");

    AST_MASK: assert property (
        live && st_reg.burst == BURST_WRITE
        |=> st_reg.arr.wr &&
            st_reg.arr.wen_rise == ~$past(i_wr.write_byte_mask_rise) &&
            st_reg.arr.wen_fall == ~$past(i_wr.write_byte_mask_fall))
        else $error("byte mask not applied with its data");

    AST_DLL: assert property (
        live && cmd_valid && cmd_code == CMD_MODE &&
        i_cmd.bank_select == BANK_EXT_MODE
        |=> st_reg.dll_en ==
            !$past(i_cmd.row_column_address_bus[EMR_DLL_BIT]))
        else $error("loop enable not loaded");

    AST_POWER_DOWN: assert property (
        live && !i_cke && !cmd_valid && st_reg.bank_open == '0 &&
        st_reg.burst == BURST_IDLE
        |=> o_power_down && !o_clock_suspended)
        else $error("power-down not entered with banks idle");

    AST_BEAT_STEP: assert property (
        live && st_reg.burst != BURST_IDLE && !last_pair && !cmd_valid
        |=> st_reg.beat == $past(st_reg.beat) + BEAT_STEP ##1 1'b1)
        else $error("burst counter did not advance two words");

    AST_PAIR_ORDER: assert property (
        st_reg.arr.rd || st_reg.arr.wr
        |-> st_reg.arr.addr_rise[0] != st_reg.arr.addr_fall[0])
        else $error("phase words not adjacent in burst");
endmodule : ddr_cmd_front

`default_nettype wire

// >>> rtl/ddr_cmd_pkg.sv
`timescale 1ns/1ns
`default_nettype none

package ddr_cmd_pkg;
    localparam int unsigned N_BANKS = 4;
    localparam int unsigned BANK_W  = 2;
    localparam int unsigned ROW_W   = 13;
    localparam int unsigned COL_W   = 9;
    localparam int unsigned DQ_W    = 16;
    localparam int unsigned MASK_W  = 2;
    localparam int unsigned ADDR_W  = BANK_W + ROW_W + COL_W;
    localparam int unsigned AP_BIT  = 10;

    // command code is {ras_n, cas_n, we_n}
    localparam logic [2:0] CMD_MODE      = 3'h0;
    localparam logic [2:0] CMD_REFRESH   = 3'h1;
    localparam logic [2:0] CMD_PRECHARGE = 3'h2;
    localparam logic [2:0] CMD_ROW_OPEN  = 3'h3;
    localparam logic [2:0] CMD_WRITE     = 3'h4;
    localparam logic [2:0] CMD_READ      = 3'h5;

    // mode and extended mode fields
    localparam logic [1:0] BANK_MODE     = 2'h0;
    localparam logic [1:0] BANK_EXT_MODE = 2'h1;
    localparam int unsigned MR_BL_LSB    = 0;
    localparam int unsigned MR_BT_BIT    = 3;
    localparam int unsigned MR_CL_LSB    = 4;
    localparam int unsigned EMR_DLL_BIT  = 0;
    localparam logic [2:0] BL_CODE_4     = 3'h2;
    localparam logic [2:0] BL_CODE_8     = 3'h3;
    localparam logic [2:0] CL_CODE_25    = 3'h6;
    localparam logic [2:0] CL_CODE_3     = 3'h3;
    localparam logic [3:0] BL_LEN_2      = 4'h2;
    localparam logic [3:0] BL_LEN_4      = 4'h4;
    localparam logic [3:0] BL_LEN_8      = 4'h8;
    localparam logic [2:0] BEAT_STEP     = 3'h2;

    typedef enum logic [1:0] {
        BURST_IDLE  = 2'b00,
        BURST_READ  = 2'b01,
        BURST_WRITE = 2'b10
    } burst_e;

    typedef enum logic [1:0] {
        PM_ACTIVE       = 2'b00,
        PM_SUSPEND      = 2'b01,
        PM_POWER_DOWN   = 2'b10,
        PM_SELF_REFRESH = 2'b11
    } power_e;

    typedef struct packed {
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic [BANK_W-1:0] bank_select;
        logic [ROW_W-1:0]  row_column_address_bus;
    } cmd_s;

    typedef struct packed {
        logic [DQ_W-1:0] rise;
        logic [DQ_W-1:0] fall;
    } pair_s;

    typedef struct packed {
        pair_s             data;
        logic [MASK_W-1:0] write_byte_mask_rise;
        logic [MASK_W-1:0] write_byte_mask_fall;
    } wr_in_s;

    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [ADDR_W-1:0] addr_rise;
        logic [ADDR_W-1:0] addr_fall;
        pair_s             wdata;
        logic [MASK_W-1:0] wen_rise;
        logic [MASK_W-1:0] wen_fall;
    } arr_req_s;

    typedef struct packed {
        logic  valid;
        pair_s data;
    } rd_out_s;

    typedef struct packed {
        logic                           cke_prev;
        power_e                         pm;
        logic [N_BANKS-1:0]             bank_open;
        logic [N_BANKS-1:0][ROW_W-1:0]  open_row;
        logic [2:0]                     bl_code;
        logic                           interleave;
        logic [2:0]                     cl_code;
        logic                           dll_en;
        burst_e                         burst;
        logic [BANK_W-1:0]              bbank;
        logic [ROW_W-1:0]               brow;
        logic [COL_W-1:0]               bcol;
        logic [2:0]                     beat;
        logic                           bap;
        arr_req_s                       arr;
        logic                           rd1_v;
        pair_s                          rd1;
        logic                           prev_v;
        logic [DQ_W-1:0]                prev_fall;
        rd_out_s                        rd;
    } state_s;

    // zero codes read as burst of 2, sequential, latency 2, loop off
    localparam state_s ST_RESET = '0;
endpackage : ddr_cmd_pkg

module burst_addr_gen
    import ddr_cmd_pkg::*;
(
    // burst setup
    input  wire logic [COL_W-1:0] i_start_col,
    input  wire logic [2:0]       i_beat,
    input  wire logic [3:0]       i_burst_len,
    input  wire logic             i_interleave,
    // word column
    output logic      [COL_W-1:0] o_col
);
    logic [2:0] wrap_mask;
    logic [2:0] low;

    always_comb begin
        wrap_mask = 3'(i_burst_len - 4'h1);
        // wrap inside the burst-aligned block, never carry upward
        if (i_interleave) begin
            low = i_start_col[2:0] ^ i_beat;
        end else begin
            low = i_start_col[2:0] + i_beat;
        end
        o_col = {i_start_col[COL_W-1:3],
                 (i_start_col[2:0] & ~wrap_mask) | (low & wrap_mask)};
    end
endmodule : burst_addr_gen

`default_nettype wire

// >>> test/ddr_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none

module ddr_ctrl_model
    import ddr_cmd_pkg::*;
(
    // clock
    input  wire logic i_mclk,
    // pins toward the memory
    output logic      o_cke,
    output cmd_s      o_cmd,
    output wr_in_s    o_wr
);
    logic [N_BANKS-1:0] open_q;

    function automatic cmd_s mk(input logic cs_n, input logic [2:0] code,
                                input logic [1:0] ba, input logic [12:0] a);
        mk = '{cs_n, code[2], code[1], code[0], ba, a};
    endfunction : mk

    initial begin
        o_cke  = 1'b1;
        o_cmd  = mk(1'b1, 3'h7, 2'h0, 13'h0000);
        o_wr   = '0;
        open_q = '0;
    end

    // deselected lines toggle so a stale value is never mistaken for a command
    task automatic nop();
        cmd_s t;
        t = ~o_cmd;
        t.cs_n = 1'b1;
        o_cmd = t;
    endtask : nop

    // pins change only just after the rising edge
    task automatic drive(input logic cs_n, input logic [2:0] code,
                         input logic [1:0] ba, input logic [12:0] a);
        @(posedge i_mclk);
        #1;
        o_cmd = mk(cs_n, code, ba, a);
        @(posedge i_mclk);
        #1;
        nop();
    endtask : drive

    task automatic issue(input logic [2:0] code, input logic [1:0] ba,
                         input logic [12:0] a);
        if ((code == CMD_READ || code == CMD_WRITE) && !open_q[ba]) begin
            drive(1'b0, CMD_ROW_OPEN, ba, 13'h0000);
            open_q[ba] = 1'b1;
        end
        if (code == CMD_ROW_OPEN && open_q[ba]) begin
            drive(1'b0, CMD_PRECHARGE, ba, 13'h0000);
        end
        drive(1'b0, code, ba, a);
        if (code == CMD_ROW_OPEN) begin
            open_q[ba] = 1'b1;
        end
        if (code == CMD_PRECHARGE || ((code == CMD_READ || code == CMD_WRITE)
                                      && a[AP_BIT])) begin
            open_q[ba] = 1'b0;
        end
    endtask : issue

    task automatic set_wr(input wr_in_s w);
        o_wr = w;
    endtask : set_wr

    task automatic set_cke(input logic v);
        @(posedge i_mclk);
        #1;
        o_cke = v;
    endtask : set_cke

    // refresh rate duty is not exercised at full length in a short run
    task automatic enter_low(input logic self_ref);
        for (int b = 0; b < N_BANKS; b++) begin
            if (open_q[b]) begin
                issue(CMD_PRECHARGE, 2'(b), 13'h0000);
            end
        end
        @(posedge i_mclk);
        #1;
        o_cke = 1'b0;
        if (self_ref) begin
            o_cmd = mk(1'b0, CMD_REFRESH, 2'h0, 13'h0000);
        end
        @(posedge i_mclk);
        #1;
        nop();
    endtask : enter_low
endmodule : ddr_ctrl_model

`default_nettype wire

// >>> test/ddr_sdram_cmd_addr_clock_enable_bench.sv
`timescale 1ns/1ns
`default_nettype none

module ddr_sdram_cmd_addr_clock_enable_bench;
    import ddr_cmd_pkg::*;

    logic               mclk;
    logic               rst_n;
    logic               cke;
    cmd_s               cmd;
    wr_in_s             wr;
    pair_s              arr_rdata;
    arr_req_s           arr;
    rd_out_s            rd;
    logic [N_BANKS-1:0] bank_open;
    logic               dll;
    logic               susp;
    logic               pdn;
    logic               sref;
    int                 n_errors;
    int                 n_tests;

    // array model: every word is a fixed function of its own address
    assign arr_rdata = '{rise: arr.addr_rise[15:0] ^ 16'h5A5A,
                         fall: arr.addr_fall[15:0] ^ 16'h5A5A};

    ddr_ctrl_model ctrl_u (.i_mclk(mclk), .o_cke(cke), .o_cmd(cmd),
                           .o_wr(wr));

    ddr_cmd_front dut_u (.i_mclk(mclk), .i_reset_n(rst_n), .i_cke(cke),
        .i_cmd(cmd), .i_wr(wr), .i_arr_rdata(arr_rdata), .o_arr(arr),
        .o_rd(rd), .o_bank_open(bank_open), .o_dll_enable(dll),
        .o_clock_suspended(susp), .o_power_down(pdn),
        .o_self_refresh(sref));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic conclude();
        $display("tests %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc

    function automatic logic [8:0] ecol(input logic [8:0] s, input int i,
                                        input int len, input logic il);
        logic [8:0] m;
        m = 9'(len - 1);
        ecol = il ? ((s & ~m) | ((s ^ 9'(i)) & m))
                  : ((s & ~m) | ((s + 9'(i)) & m));
    endfunction : ecol

    function automatic logic [15:0] ew(input logic [12:0] r,
                                       input logic [8:0] c);
        ew = {r[6:0], c} ^ 16'h5A5A;
    endfunction : ew

    task automatic run_read(input logic [12:0] mw, input logic [1:0] ba,
                            input logic [12:0] row, input logic [12:0] ca);
        int         len;
        int         p;
        int         q;
        int         frd;
        int         fv;
        logic [8:0] c;
        logic [2:0] blc;
        logic [2:0] clc;
        logic       il;
        blc = mw[2:0];
        il = mw[3];
        clc = mw[6:4];
        len = (blc == BL_CODE_4) ? 4 : (blc == BL_CODE_8) ? 8 : 2;
        p = 0;
        q = 0;
        frd = -1;
        fv = -1;
        ctrl_u.issue(CMD_MODE, BANK_MODE, mw);
        ctrl_u.issue(CMD_ROW_OPEN, ba, row);
        chk(bank_open[ba], 1'b1);
        ctrl_u.issue(CMD_READ, ba, ca);
        for (int i = 0; i < 20; i++) begin
            cyc(1);
            if (arr.rd === 1'b1) begin
                frd = (frd < 0) ? i : frd;
                c = ecol(ca[8:0], 2 * p, len, il);
                chk(arr.addr_rise, {ba, row, c});
                c = ecol(ca[8:0], 2 * p + 1, len, il);
                chk(arr.addr_fall, {ba, row, c});
                p++;
            end
            if (rd.valid === 1'b1) begin
                fv = (fv < 0) ? i : fv;
                if (2 * q < len && clc != CL_CODE_25) begin
                    c = ecol(ca[8:0], 2 * q, len, il);
                    chk(rd.data.rise, ew(row, c));
                    c = ecol(ca[8:0], 2 * q + 1, len, il);
                    chk(rd.data.fall, ew(row, c));
                end
                // half clock: each rise word is the previous fall word
                if (clc == CL_CODE_25 && q > 0 && 2 * q <= len) begin
                    c = ecol(ca[8:0], 2 * q - 1, len, il);
                    chk(rd.data.rise, ew(row, c));
                end
                if (clc == CL_CODE_25 && 2 * q < len) begin
                    c = ecol(ca[8:0], 2 * q, len, il);
                    chk(rd.data.fall, ew(row, c));
                end
                q++;
            end
        end
        chk(p, len / 2);
        chk(q, len / 2 + ((clc == CL_CODE_25) ? 1 : 0));
        chk(fv - frd, (clc == CL_CODE_3) ? 2 : 1);
    endtask : run_read

    task automatic t_reads();
        run_read({6'h00, 3'h0, 1'b0, BL_CODE_4}, 2'h2, 13'h1ABC,
                 13'h0001);
        run_read({6'h00, CL_CODE_3, 1'b1, BL_CODE_8}, 2'h1, 13'h0F0F,
                 13'h0005);
        run_read({6'h00, CL_CODE_25, 1'b0, 3'h0}, 2'h3, 13'h1555,
                 13'h01FF);
        run_read({6'h00, 3'h0, 1'b0, BL_CODE_4}, 2'h2, 13'h0123,
                 13'h0402);
        chk(bank_open[2], 1'b0);
        ctrl_u.drive(1'b1, CMD_ROW_OPEN, 2'h2, 13'h0000);
        cyc(1);
        chk(bank_open[2], 1'b0);
        $display("test reads done");
    endtask : t_reads

    task automatic t_dll_write();
        int     hits;
        wr_in_s w0;
        wr_in_s w1;
        hits = 0;
        w0 = '{data: '{rise: 16'h1234, fall: 16'hABCD},
               write_byte_mask_rise: 2'h1, write_byte_mask_fall: 2'h2};
        w1 = '{data: '{rise: 16'h5678, fall: 16'hEF01},
               write_byte_mask_rise: 2'h2, write_byte_mask_fall: 2'h1};
        ctrl_u.issue(CMD_MODE, BANK_EXT_MODE, 13'h0000);
        cyc(1);
        chk(dll, 1'b1);
        ctrl_u.issue(CMD_MODE, BANK_EXT_MODE, 13'h0001);
        cyc(1);
        chk(dll, 1'b0);
        // burst of 4 so data and mask change between the two pairs
        ctrl_u.issue(CMD_MODE, BANK_MODE, {10'h000, BL_CODE_4});
        ctrl_u.set_wr(w0);
        ctrl_u.issue(CMD_WRITE, 2'h0, 13'h0004);
        for (int i = 0; i < 6; i++) begin
            cyc(1);
            ctrl_u.set_wr(w1);
            if (arr.wr === 1'b1) begin
                chk(arr.wdata, hits ? 32'h5678EF01 : 32'h1234ABCD);
                chk(arr.wen_rise, hits ? 2'h1 : 2'h2);
                chk(arr.wen_fall, hits ? 2'h2 : 2'h1);
                chk(arr.addr_rise, 32'h4 + 2 * hits);
                chk(arr.addr_fall, 32'h5 + 2 * hits);
                hits++;
            end
        end
        chk(hits, 2);
        $display("test dll and write done");
    endtask : t_dll_write

    task automatic t_low_power();
        logic [16:0] held;
        ctrl_u.issue(CMD_MODE, BANK_MODE, {9'h000, 1'b0, BL_CODE_8});
        ctrl_u.issue(CMD_READ, 2'h0, 13'h0000);
        ctrl_u.set_cke(1'b0);
        cyc(1);
        held = {rd.valid, rd.data.fall};
        ctrl_u.drive(1'b0, CMD_PRECHARGE, 2'h0, 13'h0000);
        for (int i = 0; i < 3; i++) begin
            chk(arr.rd, 1'b0);
            chk({rd.valid, rd.data.fall}, held);
            cyc(1);
        end
        chk(bank_open[0], 1'b1);
        chk({susp, pdn}, 2'h2);
        ctrl_u.set_cke(1'b1);
        cyc(12);
        chk(susp, 1'b0);
        ctrl_u.enter_low(1'b0);
        cyc(2);
        chk({pdn, susp, bank_open}, 6'h20);
        ctrl_u.set_cke(1'b1);
        cyc(2);
        chk(pdn, 1'b0);
        ctrl_u.enter_low(1'b1);
        cyc(2);
        chk(sref, 1'b1);
        ctrl_u.set_cke(1'b1);
        cyc(2);
        chk(sref, 1'b0);
        $display("test low power done");
    endtask : t_low_power

    initial begin
        n_errors = 0;
        n_tests = 0;
        rst_n = 1'b0;
        repeat (12) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        cyc(2);
        t_reads();
        t_dll_write();
        t_low_power();
        conclude();
    end

    // whole run needs a few hundred cycles
    initial begin
        #(40 * 4000);
        n_errors++;
        conclude();
    end
endmodule : ddr_sdram_cmd_addr_clock_enable_bench

`default_nettype wire
